// >>> hw/bci_pkg.sv
// package of constants and types for the bus control and interrupt block
package bci_pkg;
  // reference clock ticks per machine cycle and phase points
  localparam int CLK_DIV = 4;
  localparam logic [1:0] PH_P1_END = 2'h1;
  localparam logic [1:0] PH_P2_SAMPLE = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [1:0] PH_STEP = 2'h1;
  // initialisation sequence layout, six cycles numbered 0..5
  localparam logic [2:0] INIT_PUSH_PCH = 3'h2;
  localparam logic [2:0] INIT_PUSH_PCL = 3'h3;
  localparam logic [2:0] INIT_PUSH_P = 3'h4;
  localparam logic [2:0] INIT_LAST = 3'h5;
  localparam logic [2:0] INIT_STEP = 3'h1;
  // vectors
  localparam logic [15:0] VEC_EDGE_LO = 16'hFFFA;
  localparam logic [15:0] VEC_EDGE_HI = 16'hFFFB;
  localparam logic [15:0] VEC_RST_LO = 16'hFFFC;
  localparam logic [15:0] VEC_RST_HI = 16'hFFFD;
  localparam logic [15:0] VEC_MASK_LO = 16'hFFFE;
  localparam logic [15:0] VEC_MASK_HI = 16'hFFFF;
  // pages and pointer reset values
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] ZERO_PAGE = 8'h00;
  localparam logic [7:0] SP_RESET = 8'hFF;
  localparam logic [7:0] SP_STEP = 8'h01;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;
  // status layout
  localparam int ST_BIT_D = 3;
  localparam int ST_BIT_I = 2;
  localparam int ST_BIT_V = 6;
  localparam logic [7:0] STATUS_RESET = 8'h24;
  // addressing mode and access kind reported by the execution core
  typedef enum logic [1:0] {AM_IMPL, AM_IMM, AM_ZP, AM_ABS} bci_amode_t;
  typedef enum logic [1:0] {AC_READ, AC_WRITE, AC_RMW} bci_access_t;
  typedef struct packed {
    bci_amode_t amode;
    bci_access_t access;
  } bci_mode_t;
  // which vector the next vector fetch uses
  typedef enum logic [1:0] {VS_RESET, VS_EDGE, VS_MASK} bci_vsel_t;
  // one machine cycle as seen on the bus
  typedef struct packed {
    logic [15:0] addr;
    logic write;
    logic [7:0] wdata;
    logic lock_n;
    logic sync;
  } bci_bus_t;
endpackage

// >>> hw/bci_fall_detect.sv
// falling edge detector sampled on an enable pulse
`timescale 1ns/1ns
module bci_fall_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_en,
  input wire logic din,
  output logic fell
);
  // last sampled level; idles high so a low at reset counts as an edge at the first sample
  logic prev_reg;

  // fell pulses for one tick when a sample finds high turned low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 1'b1;
      fell <= 1'b0;
    end else if (sample_en) begin
      prev_reg <= din;
      fell <= prev_reg & ~din;
    end else begin
      fell <= 1'b0;
    end
  end
endmodule

// >>> hw/bci_ctrl.sv
// bus control, interrupt entry and initialisation sequencer
`timescale 1ns/1ns
module bci_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic initialize_input_n,
  input wire logic mask_int_req_n,
  input wire logic edge_int_n,
  input wire logic rdy,
  input wire logic set_ovf_n,
  input wire logic bus_drive_enable,
  input wire logic data_output_gate,
  input wire logic [7:0] data_bus_in,
  input wire bci_pkg::bci_mode_t core_mode,
  input wire logic [7:0] core_wdata,
  input wire logic core_status_we,
  input wire logic [7:0] core_status_val,
  output logic phi1_out,
  output logic phi2_out,
  output logic oscillator_feedback_output,
  output logic [15:0] address_bus,
  output logic address_bus_oe_n,
  output logic rw_out,
  output logic rw_oe_n,
  output logic [7:0] data_bus_out,
  output logic data_bus_oe_n,
  output logic bus_lock_output_n,
  output logic opfetch_marker,
  output logic [7:0] opcode_out,
  output logic [7:0] operand_out,
  output logic operand_vld,
  output logic [7:0] status_out
);
  import bci_pkg::*;

  typedef enum logic [3:0] {
    S_HOLD, S_INIT, S_INT_PCH, S_INT_PCL, S_INT_P, S_VEC_LO, S_VEC_HI,
    S_FETCH, S_IMPL, S_OPLO, S_OPHI, S_DATA, S_MODIFY, S_WRITE
  } bci_state_t;

  logic [1:0] ph_reg; // tick within machine cycle
  logic [1:0] ph_next;
  logic phi1_reg, phi2_reg, osc_reg;
  bci_state_t state_reg;
  logic [2:0] init_cnt_reg; // step of initialisation sequence
  bci_vsel_t vsel_reg;
  bci_mode_t mode_reg; // mode of the instruction in flight
  logic [15:0] pc_reg;
  logic [15:0] ea_reg; // effective address
  logic [7:0] sp_reg;
  logic [7:0] status_reg;
  logic [7:0] opcode_reg;
  logic [7:0] operand_reg;
  logic vld_reg;
  logic irq_seen_reg; // maskable level seen in phase two
  logic nmi_pend_reg; // edge interrupt waiting for entry
  logic nmi_fell, so_fell;
  logic nmi_req; // edge request pending or arriving this tick
  logic adv; // machine cycle completes this tick
  logic last_cyc; // current cycle ends an instruction
  logic take_int;
  logic enter_int;
  bci_bus_t bus_cur; // what the present state puts on the bus
  bci_bus_t bus_reg;
  logic addr_oe_n_reg, data_oe_n_reg;

  assign ph_next = ph_reg + PH_STEP;
  // ready low on the closing tick stretches the cycle, so the state and
  // with it the address stay put; covers write cycles too
  assign adv = (ph_reg == PH_LAST) && rdy;
  // the edge interrupt wins over the maskable one; an edge sampled in
  // the closing cycle counts at once, as a maskable level would
  assign nmi_req = nmi_pend_reg | nmi_fell;
  assign take_int = nmi_req |
    (irq_seen_reg & ~status_reg[ST_BIT_I]);
  assign enter_int = adv && last_cyc && take_int;

  // clock generator: four reference ticks per phase-two period
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_reg <= 2'h0;
      phi1_reg <= 1'b1;
      phi2_reg <= 1'b0;
      osc_reg <= 1'b1;
    end else begin
      ph_reg <= ph_next;
      phi2_reg <= ph_next[1];
      phi1_reg <= ~ph_next[1];
      osc_reg <= ~ph_next[0];
    end
  end

  // edge interrupt sampled in phase two, overflow at phase one end
  bci_fall_detect u_edge_int (
    .clk(ref_clk),
    .rst_n(rst_n),
    .sample_en(ph_reg == PH_P2_SAMPLE),
    .din(edge_int_n),
    .fell(nmi_fell)
  );
  bci_fall_detect u_set_ovf (
    .clk(ref_clk),
    .rst_n(rst_n),
    .sample_en(ph_reg == PH_P1_END),
    .din(set_ovf_n),
    .fell(so_fell)
  );

  // maskable request is a level; only a sample with ready high counts
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_seen_reg <= 1'b0;
    end else if (ph_reg == PH_P2_SAMPLE && rdy) begin
      irq_seen_reg <= ~mask_int_req_n;
    end
  end

  // pending edge: a new edge landing on the entry tick is kept
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_pend_reg <= 1'b0;
    end else begin
      nmi_pend_reg <= enter_int ? (nmi_fell & nmi_pend_reg) :
        nmi_req;
    end
  end

  // which cycles close an instruction
  always_comb begin
    last_cyc = 1'b0;
    case (state_reg)
      S_IMPL: last_cyc = 1'b1;
      S_OPLO: last_cyc = (mode_reg.amode == AM_IMM);
      S_DATA: last_cyc = (mode_reg.access != AC_RMW);
      S_WRITE: last_cyc = 1'b1;
      default: last_cyc = 1'b0;
    endcase
  end

  // sequencer: state, program counter, stack pointer, operands
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_HOLD;
      init_cnt_reg <= 3'h0;
      vsel_reg <= VS_RESET;
      mode_reg <= '0;
      pc_reg <= PC_RESET;
      ea_reg <= 16'h0000;
      sp_reg <= SP_RESET;
      opcode_reg <= 8'h00;
      operand_reg <= 8'h00;
      vld_reg <= 1'b0;
    end else if (!initialize_input_n) begin
      // a low initialise input stops activity at once
      state_reg <= S_HOLD;
      init_cnt_reg <= 3'h0;
      vld_reg <= 1'b0;
    end else begin
      vld_reg <= 1'b0;
      if (adv && last_cyc) begin
        state_reg <= take_int ? S_INT_PCH : S_FETCH;
        vsel_reg <= nmi_req ? VS_EDGE : VS_MASK;
      end
      if (adv) begin
        case (state_reg)
          S_HOLD: begin
            // rising initialise input starts the sequence
            state_reg <= S_INIT;
            init_cnt_reg <= 3'h0;
          end
          S_INIT: begin
            if (init_cnt_reg >= INIT_PUSH_PCH &&
                init_cnt_reg <= INIT_PUSH_P) begin
              sp_reg <= sp_reg - SP_STEP;
            end
            if (init_cnt_reg == INIT_LAST) begin
              state_reg <= S_VEC_LO;
              vsel_reg <= VS_RESET;
            end else begin
              init_cnt_reg <= init_cnt_reg + INIT_STEP;
            end
          end
          S_INT_PCH: begin
            sp_reg <= sp_reg - SP_STEP;
            state_reg <= S_INT_PCL;
          end
          S_INT_PCL: begin
            sp_reg <= sp_reg - SP_STEP;
            state_reg <= S_INT_P;
          end
          S_INT_P: begin
            sp_reg <= sp_reg - SP_STEP;
            state_reg <= S_VEC_LO;
          end
          S_VEC_LO: begin
            pc_reg[7:0] <= data_bus_in;
            state_reg <= S_VEC_HI;
          end
          S_VEC_HI: begin
            pc_reg[15:8] <= data_bus_in;
            state_reg <= S_FETCH;
          end
          S_FETCH: begin
            opcode_reg <= data_bus_in;
            mode_reg <= core_mode;
            pc_reg <= pc_reg + PC_STEP;
            state_reg <= (core_mode.amode == AM_IMPL) ? S_IMPL : S_OPLO;
          end
          S_OPLO: begin
            pc_reg <= pc_reg + PC_STEP;
            if (mode_reg.amode == AM_IMM) begin
              // operand is the byte itself, no further access
              operand_reg <= data_bus_in;
              vld_reg <= 1'b1;
            end else if (mode_reg.amode == AM_ZP) begin
              ea_reg <= {ZERO_PAGE, data_bus_in};
              state_reg <= S_DATA;
            end else begin
              ea_reg[7:0] <= data_bus_in;
              state_reg <= S_OPHI;
            end
          end
          S_OPHI: begin
            pc_reg <= pc_reg + PC_STEP;
            ea_reg[15:8] <= data_bus_in;
            state_reg <= S_DATA;
          end
          S_DATA: begin
            if (mode_reg.access != AC_WRITE) begin
              operand_reg <= data_bus_in;
              vld_reg <= 1'b1;
            end
            if (mode_reg.access == AC_RMW) begin
              state_reg <= S_MODIFY;
            end
          end
          S_MODIFY: state_reg <= S_WRITE;
          default: begin
            // closing cycles were handled above
          end
        endcase
      end
    end
  end

  // status: core writes first, hardware sets override them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= STATUS_RESET;
    end else begin
      if (core_status_we) begin
        status_reg <= core_status_val;
      end
      if (adv && state_reg == S_INIT && init_cnt_reg == INIT_LAST) begin
        status_reg[ST_BIT_I] <= 1'b1;
        status_reg[ST_BIT_D] <= 1'b0;
      end
      if (adv && state_reg == S_INT_P) begin
        status_reg[ST_BIT_I] <= 1'b1;
      end
      if (so_fell) begin
        status_reg[ST_BIT_V] <= 1'b1;
      end
    end
  end

  // bus cycle implied by the present state
  always_comb begin
    bus_cur.addr = pc_reg;
    bus_cur.write = 1'b0;
    bus_cur.wdata = 8'h00;
    bus_cur.lock_n = 1'b1;
    bus_cur.sync = 1'b0;
    case (state_reg)
      S_INIT: begin
        if (init_cnt_reg >= INIT_PUSH_PCH &&
            init_cnt_reg <= INIT_PUSH_P) begin
          bus_cur.addr = {STACK_PAGE, sp_reg};
          bus_cur.write = 1'b1;
          if (init_cnt_reg == INIT_PUSH_PCH) begin
            bus_cur.wdata = pc_reg[15:8];
          end else if (init_cnt_reg == INIT_PUSH_PCL) begin
            bus_cur.wdata = pc_reg[7:0];
          end else begin
            bus_cur.wdata = status_reg;
          end
        end
      end
      S_INT_PCH: begin
        bus_cur.addr = {STACK_PAGE, sp_reg};
        bus_cur.write = 1'b1;
        bus_cur.wdata = pc_reg[15:8];
      end
      S_INT_PCL: begin
        bus_cur.addr = {STACK_PAGE, sp_reg};
        bus_cur.write = 1'b1;
        bus_cur.wdata = pc_reg[7:0];
      end
      S_INT_P: begin
        bus_cur.addr = {STACK_PAGE, sp_reg};
        bus_cur.write = 1'b1;
        bus_cur.wdata = status_reg;
      end
      S_VEC_LO: begin
        if (vsel_reg == VS_RESET) begin
          bus_cur.addr = VEC_RST_LO;
        end else if (vsel_reg == VS_EDGE) begin
          bus_cur.addr = VEC_EDGE_LO;
        end else begin
          bus_cur.addr = VEC_MASK_LO;
        end
      end
      S_VEC_HI: begin
        if (vsel_reg == VS_RESET) begin
          bus_cur.addr = VEC_RST_HI;
        end else if (vsel_reg == VS_EDGE) begin
          bus_cur.addr = VEC_EDGE_HI;
        end else begin
          bus_cur.addr = VEC_MASK_HI;
        end
      end
      S_FETCH: bus_cur.sync = 1'b1;
      S_DATA: begin
        bus_cur.addr = ea_reg;
        bus_cur.write = (mode_reg.access == AC_WRITE);
        bus_cur.wdata = core_wdata;
      end
      S_MODIFY: begin
        // old value written back while the arbiter is held off
        bus_cur.addr = ea_reg;
        bus_cur.write = 1'b1;
        bus_cur.wdata = operand_reg;
        bus_cur.lock_n = 1'b0;
      end
      S_WRITE: begin
        bus_cur.addr = ea_reg;
        bus_cur.write = 1'b1;
        bus_cur.wdata = core_wdata;
        bus_cur.lock_n = 1'b0;
      end
      default: begin
        // hold, implied and operand cycles read at the counter
      end
    endcase
  end

  // bus outputs registered one tick after the state; a halted cycle
  // keeps every field but the write data, so address and marker stay valid
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_reg <= '{addr: PC_RESET, write: 1'b0, wdata: 8'h00,
                   lock_n: 1'b1, sync: 1'b0};
    end else begin
      bus_reg <= bus_cur;
    end
  end

  // output enables, low while driving; data only on writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_oe_n_reg <= 1'b1;
      data_oe_n_reg <= 1'b1;
    end else begin
      addr_oe_n_reg <= ~bus_drive_enable;
      data_oe_n_reg <= ~(bus_drive_enable && data_output_gate &&
        bus_cur.write);
    end
  end

  assign phi1_out = phi1_reg;
  assign phi2_out = phi2_reg;
  assign oscillator_feedback_output = osc_reg;
  assign address_bus = bus_reg.addr;
  assign address_bus_oe_n = addr_oe_n_reg;
  assign rw_out = ~bus_reg.write;
  assign rw_oe_n = addr_oe_n_reg;
  assign data_bus_out = bus_reg.wdata;
  assign data_bus_oe_n = data_oe_n_reg;
  assign bus_lock_output_n = bus_reg.lock_n;
  assign opfetch_marker = bus_reg.sync;
  assign opcode_out = opcode_reg;
  assign operand_out = operand_reg;
  assign operand_vld = vld_reg;
  assign status_out = status_reg;
endmodule

// >>> verif/bci_ctrl_props.sv
// concurrent checks on the pins of the bus control block
`timescale 1ns/1ns
module bci_ctrl_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic initialize_input_n,
  input wire logic rdy,
  input wire logic set_ovf_n,
  input wire logic bus_drive_enable,
  input wire logic data_output_gate,
  input wire logic phi1_out,
  input wire logic phi2_out,
  input wire logic [15:0] address_bus,
  input wire logic address_bus_oe_n,
  input wire logic rw_out,
  input wire logic rw_oe_n,
  input wire logic data_bus_oe_n,
  input wire logic bus_lock_output_n,
  input wire logic opfetch_marker,
  input wire logic [7:0] status_out
);
  default clocking @(posedge ref_clk); endclocking
  // a low initialise input cuts any cycle short, so checks pause then
  default disable iff (!rst_n || !initialize_input_n);

  // modify write then final write, one address, four ticks each
  sequence locked_pair;
    (!bus_lock_output_n && !rw_out && $stable(address_bus))[*8];
  endsequence
  // a whole opcode fetch cycle is a read with the marker up
  sequence fetch_cycle;
    (opfetch_marker && rw_out)[*4];
  endsequence
  // phase two is two ticks high, two low
  sequence ph2_wave;
    ##1 phi2_out ##1 !phi2_out[*2] ##1 phi2_out;
  endsequence

  clk_inverse_a: assert property (phi1_out != phi2_out)
    else $error("phase one is not the inverse of phase two");
  clk_period_a: assert property ($rose(phi2_out) |-> ph2_wave)
    else $error("phase two period is not four ticks");
  addr_float_a: assert property (!bus_drive_enable |=>
    address_bus_oe_n && rw_oe_n)
    else $error("address or direction driven with drive enable low");
  data_float_a: assert property (!(bus_drive_enable && data_output_gate)
    |=> data_bus_oe_n)
    else $error("data driven while enable or gate low");
  read_quiet_a: assert property (rw_out && $past(rw_out)
    |-> data_bus_oe_n)
    else $error("data driven during a read");
  halt_hold_a: assert property (!$past(rdy) && !$past(rdy, 2)
    |-> $stable(address_bus))
    else $error("address moved while halted");
  ovf_set_a: assert property ($fell(set_ovf_n) |->
    ##[1:8] status_out[6])
    else $error("overflow bit not set after falling input");
  lock_pair_a: assert property ($fell(bus_lock_output_n)
    |-> locked_pair)
    else $error("lock not held over two writes");
  fetch_mark_a: assert property ($rose(opfetch_marker)
    |-> fetch_cycle)
    else $error("fetch marker dropped inside the fetch cycle");
endmodule

bind bci_ctrl bci_ctrl_props u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .initialize_input_n(initialize_input_n),
  .rdy(rdy), .set_ovf_n(set_ovf_n), .bus_drive_enable(bus_drive_enable),
  .data_output_gate(data_output_gate), .phi1_out(phi1_out),
  .phi2_out(phi2_out), .address_bus(address_bus),
  .address_bus_oe_n(address_bus_oe_n), .rw_out(rw_out),
  .rw_oe_n(rw_oe_n), .data_bus_oe_n(data_bus_oe_n),
  .bus_lock_output_n(bus_lock_output_n),
  .opfetch_marker(opfetch_marker), .status_out(status_out));

// >>> verif/bci_mem_model.sv
// memory and peripheral model on the far side of the bus
`timescale 1ns/1ns
module bci_mem_model (
  input wire logic clk,
  input wire logic phi2,
  input wire logic [15:0] addr,
  input wire logic rw,
  input wire logic [7:0] wdata,
  input wire logic wdata_oe_n,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:65535]; // whole space, filled by the bench
  logic [7:0] last_reg = 8'h5a; // last value seen on the lines

  // store only while the processor really drives write data
  always @(posedge clk) begin
    if (phi2 && !rw && !wdata_oe_n) begin
      mem[addr] <= wdata;
    end
    last_reg <= rdata;
  end

  // reads answer at once; otherwise the lines toggle, never hold old data
  assign rdata = rw ? mem[addr] : ~last_reg;
endmodule

// >>> verif/bci_ctrl_tb_top.sv
// self-checking bench for the bus control and interrupt block
`timescale 1ns/1ns
module bci_ctrl_tb_top;
  import bci_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ini_n = 1'b0; // documented reset pin, low at start
  logic mreq_n = 1'b1;
  logic edg_n = 1'b1;
  logic rdy = 1'b1;
  logic sovf_n = 1'b1;
  logic be = 1'b1;
  logic gate_on = 1'b1; // gate follows phase two when set
  logic dgate;
  logic swe = 1'b0;
  logic [7:0] sval = 8'h00;
  logic [7:0] cwd = 8'h00;
  bci_mode_t mode = '{AM_ZP, AC_READ};
  logic ph1, ph2, aoe_n, rw, rwoe_n, doe_n, lock_n, sync;
  logic [15:0] addr, a0;
  logic [7:0] din, dout, st, opc;
  logic [7:0] sp_exp = SP_RESET; // where the next push must land
  bci_bus_t pv, lg[$]; // cycle log as seen on the pins
  logic pv_ph2, pv_rdy;
  int err_total = 0;
  int n_checks = 0;
  int cnt;

  always #4 ref_clk = ~ref_clk;

  // gate tied straight to phase two as in a normal system; a late gate
  // would miss the phase-two window and no write would ever land
  assign dgate = gate_on & ph2;

  bci_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .initialize_input_n(ini_n), .mask_int_req_n(mreq_n),
    .edge_int_n(edg_n), .rdy(rdy), .set_ovf_n(sovf_n),
    .bus_drive_enable(be), .data_output_gate(dgate), .data_bus_in(din),
    .core_mode(mode), .core_wdata(cwd), .core_status_we(swe),
    .core_status_val(sval), .phi1_out(ph1), .phi2_out(ph2),
    .oscillator_feedback_output(), .address_bus(addr),
    .address_bus_oe_n(aoe_n), .rw_out(rw), .rw_oe_n(rwoe_n),
    .data_bus_out(dout), .data_bus_oe_n(doe_n),
    .bus_lock_output_n(lock_n), .opfetch_marker(sync), .opcode_out(opc),
    .operand_out(), .operand_vld(), .status_out(st));

  bci_mem_model u_mem (.clk(ref_clk), .phi2(ph2), .addr(addr), .rw(rw),
    .wdata(dout), .wdata_oe_n(doe_n), .rdata(din));

  // log a machine cycle when phase two ends and ready let it finish
  always @(negedge ref_clk) begin
    if (rst_n && pv_ph2 && !ph2 && pv_rdy) begin
      lg.push_back(pv);
    end
    pv_ph2 <= ph2;
    pv_rdy <= rdy;
    pv <= '{addr, !rw, rw ? din : dout, lock_n, sync};
  end

  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(logic ok, string m);
    n_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  // load status from the core side for one tick
  task automatic set_status(logic [7:0] v);
    sval = v;
    swe = 1'b1;
    tick(1);
    swe = 1'b0;
    tick(8);
  endtask

  // wait for the opcode fetch right after a given vector byte read
  task automatic wait_vec(logic [15:0] hi);
    lg.delete();
    for (int i = 0; i < 3000; i++) begin
      tick(1);
      if (lg.size() > 5 && lg[$].sync === 1'b1 && lg[$-1].addr === hi)
        break;
    end
  endtask

  // three pushes, a gap of idle cycles, vector pair, fetch at vector
  task automatic entry_chk(logic [15:0] lo, int gap, string m);
    int n;
    n = lg.size();
    for (int j = 0; j < 3; j++)
      chk(lg[n-6-gap+j].write === 1'b1 &&
        lg[n-6-gap+j].addr === {STACK_PAGE, sp_exp - 8'(j)}, m);
    chk(lg[n-3].addr === lo && lg[n-3].write === 1'b0, m);
    chk(lg[n-1].addr === {u_mem.mem[lo+16'h0001], u_mem.mem[lo]}, m);
    chk(st[ST_BIT_I] === 1'b1, m); // mask flag up after any entry
    sp_exp = sp_exp - 8'h03;
  endtask

  // one instruction in the given mode, checked cycle by cycle
  task automatic mode_chk(bci_mode_t m);
    int k;
    int j;
    logic [15:0] ea;
    logic [7:0] op;
    mode = m;
    cwd = 8'($urandom);
    tick(4);
    lg.delete();
    for (int i = 0; i < 400 && lg.size() < 12; i++) tick(1);
    k = 0;
    while (k < 6 && lg[k].sync !== 1'b1) k++;
    // opcode output holds the byte of the latest fetch in the log
    op = 8'h00;
    foreach (lg[i]) if (lg[i].sync === 1'b1) op = lg[i].wdata;
    chk(opc === op, "opcode");
    chk(lg[k+1].addr === lg[k].addr + 16'h0001, "operand");
    if (m.amode == AM_IMM || m.amode == AM_IMPL) begin
      chk(lg[k+2].sync === 1'b1, "imm next");
      return;
    end
    ea = {ZERO_PAGE, lg[k+1].wdata};
    j = k + 2;
    if (m.amode == AM_ABS) begin
      ea = {lg[k+2].wdata, lg[k+1].wdata};
      j = k + 3;
    end
    chk(lg[j].addr === ea, "ea");
    chk(lg[j].write === (m.access == AC_WRITE), "dir");
    if (m.access == AC_WRITE)
      chk(lg[j].wdata === cwd && lg[j].lock_n === 1'b1, "wr");
    if (m.access == AC_RMW) begin
      chk(lg[j+1] === bci_bus_t'{ea, 1'b1, lg[j].wdata, 1'b0, 1'b0},
        "modify");
      chk(lg[j+2] === bci_bus_t'{ea, 1'b1, cwd, 1'b0, 1'b0},
        "final");
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // cut a hang short well past the expected run length
  initial begin
    #400000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    void'($urandom(32'h577f_aeef));
    for (int i = 0; i < 65536; i++) u_mem.mem[i] = 8'($urandom);
    tick(6);
    rst_n = 1'b1;
    tick(12); // pin held low two machine cycles and more
    ini_n = 1'b1;
    wait_vec(VEC_RST_HI);
    entry_chk(VEC_RST_LO, 1, "reset entry");
    chk(st[ST_BIT_D] === 1'b0, "decimal");
    $display("test reset done");
    // every addressing mode and access kind in turn
    mode_chk('{AM_IMPL, AC_READ});
    mode_chk('{AM_IMM, AC_READ});
    for (int a = 2; a < 4; a++)
      for (int c = 0; c < 3; c++)
        mode_chk('{bci_amode_t'(a), bci_access_t'(c)});
    mode = '{AM_ZP, AC_RMW};
    $display("test modes done");
    // overflow input: bit clear first so the edge is the cause
    set_status(8'h00);
    chk(st[ST_BIT_V] === 1'b0, "ovf clear");
    sovf_n = 1'b0;
    tick(8);
    chk(st[ST_BIT_V] === 1'b1, "ovf set");
    sovf_n = 1'b1;
    $display("test overflow done");
    // maskable request with the mask clear by the status load above
    mreq_n = 1'b0;
    wait_vec(VEC_MASK_HI);
    mreq_n = 1'b1;
    entry_chk(VEC_MASK_LO, 0, "mask entry");
    $display("test maskable done");
    // both at once: the edge request must win
    set_status(8'h00);
    mreq_n = 1'b0;
    edg_n = 1'b0;
    wait_vec(VEC_EDGE_HI);
    mreq_n = 1'b1;
    entry_chk(VEC_EDGE_LO, 0, "edge entry");
    lg.delete();
    tick(200);
    cnt = 0;
    foreach (lg[i]) if (lg[i].addr === VEC_EDGE_HI) cnt++;
    chk(cnt == 0, "level retrigger");
    edg_n = 1'b1;
    tick(8);
    edg_n = 1'b0;
    wait_vec(VEC_EDGE_HI);
    entry_chk(VEC_EDGE_LO, 0, "nested edge");
    edg_n = 1'b1;
    $display("test edge done");
    // ready low at random points, address must freeze
    for (int i = 0; i < 6; i++) begin
      tick($urandom_range(1, 9));
      rdy = 1'b0; // ready lowered by the outside
      tick(4);
      a0 = addr;
      tick(8);
      chk(addr === a0, "halt");
      rdy = 1'b1;
    end
    for (int i = 0; i < 40 && sync !== 1'b0; i++) tick(1);
    for (int i = 0; i < 40 && sync !== 1'b1; i++) tick(1);
    rdy = 1'b0;
    a0 = addr;
    tick(12);
    chk(sync === 1'b1 && addr === a0, "step freeze");
    rdy = 1'b1;
    $display("test ready done");
    // drive enable and gate at random, then a plain float
    for (int i = 0; i < 300; i++) begin
      be = 1'($urandom);
      gate_on = 1'($urandom);
      tick(1);
    end
    be = 1'b0;
    tick(2);
    chk(aoe_n === 1'b1 && rwoe_n === 1'b1, "float addr");
    chk(doe_n === 1'b1, "float data");
    be = 1'b1;
    gate_on = 1'b1;
    $display("test float done");
    // mid-run restart with decimal mode set beforehand
    set_status(8'h08);
    ini_n = 1'b0;
    tick(12);
    ini_n = 1'b1;
    wait_vec(VEC_RST_HI);
    entry_chk(VEC_RST_LO, 1, "restart");
    chk(st[ST_BIT_D] === 1'b0, "decimal cleared");
    $display("test restart done");
    end_of_test();
  end
endmodule
